//--- logic/jtp_tap_port.v
// Test access port: controller, instruction and data registers, output buffer
`timescale 1ns/1ps
`default_nettype none
`include "jtp_defines.vh"

module jtp_tap_port #(
    parameter [31:0] ID_VALUE  = 32'h1234_5001,   // Arbitrary identification value
    parameter        BS_W      = `JTP_BS_W,
    parameter        PG_W      = `JTP_PG_W,
    parameter        SC_W      = `JTP_SC_W
) (
    input  wire            clk,
    input  wire            resetn,
    input  wire            tap_enable_fuse,
    input  wire            tap_disable_bit,
    input  wire            tck_pin,
    input  wire            tms_pin,
    input  wire            tdi_pin,
    output wire            tdo_out,
    output wire            tdo_oe,
    output wire            tap_active,
    output wire            tap_pullup_en,
    input  wire [BS_W-1:0] bs_capture,
    output reg  [BS_W-1:0] bs_update,
    input  wire [PG_W-1:0] prog_capture,
    output reg  [PG_W-1:0] prog_data,
    output wire            prog_valid,
    input  wire            prog_ready,
    input  wire [SC_W-1:0] scan_capture,
    output reg  [SC_W-1:0] scan_update,
    output reg  [SC_W-1:0] brk_update,
    output reg  [3:0]      instr_reg,
    output reg  [3:0]      tap_state_reg
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers, two stages each
reg  [2:0] sync1_reg;
reg  [2:0] sync2_reg;
reg        tck_last_reg;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        sync1_reg    <= 3'h7;
        sync2_reg    <= 3'h7;
        tck_last_reg <= 1'b1;   // Matches the preset stage, so no false rise after reset
    end else begin
        sync1_reg    <= {tck_pin, tms_pin, tdi_pin};
        sync2_reg    <= sync1_reg;
        tck_last_reg <= sync2_reg[2];
    end
end

// Port enable; pins become plain port pins otherwise
assign tap_active    = tap_enable_fuse & ~tap_disable_bit;
assign tap_pullup_en = tap_active;

// Inputs read high when pulled up and undriven by tester logic
wire tms_s   = sync2_reg[1];
wire tdi_s   = sync2_reg[0];
wire tck_s   = sync2_reg[2];
wire tck_ris = tap_active & tck_s & ~tck_last_reg;
wire tck_fal = tap_active & ~tck_s & tck_last_reg;

////////////////////////////////////////////////////////////////////////////////
// Sixteen-state controller, no test reset pin
reg [3:0] state_next;
always @* begin
    case (tap_state_reg)
        `JTP_ST_RESET:    state_next = tms_s ? `JTP_ST_RESET    : `JTP_ST_IDLE;
        `JTP_ST_IDLE:     state_next = tms_s ? `JTP_ST_SEL_DR   : `JTP_ST_IDLE;
        `JTP_ST_SEL_DR:   state_next = tms_s ? `JTP_ST_SEL_IR   : `JTP_ST_CAP_DR;
        `JTP_ST_CAP_DR:   state_next = tms_s ? `JTP_ST_EXIT1_DR : `JTP_ST_SHIFT_DR;
        `JTP_ST_SHIFT_DR: state_next = tms_s ? `JTP_ST_EXIT1_DR : `JTP_ST_SHIFT_DR;
        `JTP_ST_EXIT1_DR: state_next = tms_s ? `JTP_ST_UPD_DR   : `JTP_ST_PAUSE_DR;
        `JTP_ST_PAUSE_DR: state_next = tms_s ? `JTP_ST_EXIT2_DR : `JTP_ST_PAUSE_DR;
        `JTP_ST_EXIT2_DR: state_next = tms_s ? `JTP_ST_UPD_DR   : `JTP_ST_SHIFT_DR;
        `JTP_ST_UPD_DR:   state_next = tms_s ? `JTP_ST_SEL_DR   : `JTP_ST_IDLE;
        `JTP_ST_SEL_IR:   state_next = tms_s ? `JTP_ST_RESET    : `JTP_ST_CAP_IR;
        `JTP_ST_CAP_IR:   state_next = tms_s ? `JTP_ST_EXIT1_IR : `JTP_ST_SHIFT_IR;
        `JTP_ST_SHIFT_IR: state_next = tms_s ? `JTP_ST_EXIT1_IR : `JTP_ST_SHIFT_IR;
        `JTP_ST_EXIT1_IR: state_next = tms_s ? `JTP_ST_UPD_IR   : `JTP_ST_PAUSE_IR;
        `JTP_ST_PAUSE_IR: state_next = tms_s ? `JTP_ST_EXIT2_IR : `JTP_ST_PAUSE_IR;
        `JTP_ST_EXIT2_IR: state_next = tms_s ? `JTP_ST_UPD_IR   : `JTP_ST_SHIFT_IR;
        `JTP_ST_UPD_IR:   state_next = tms_s ? `JTP_ST_SEL_DR   : `JTP_ST_IDLE;
        default:          state_next = `JTP_ST_RESET;
    endcase
end

// Disabled port holds the controller in reset
always @(posedge clk or negedge resetn) begin
    if (!resetn)
        tap_state_reg <= `JTP_ST_RESET;
    else if (!tap_active)
        tap_state_reg <= `JTP_ST_RESET;
    else if (tck_ris)
        tap_state_reg <= state_next;
end

wire st_shift_dr = (tap_state_reg == `JTP_ST_SHIFT_DR);
wire st_shift_ir = (tap_state_reg == `JTP_ST_SHIFT_IR);
wire st_cap_dr   = (tap_state_reg == `JTP_ST_CAP_DR);
wire st_upd_dr   = (tap_state_reg == `JTP_ST_UPD_DR);

////////////////////////////////////////////////////////////////////////////////
// Instruction register, reset selects identification
reg [3:0] ir_shift_reg;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        ir_shift_reg <= 4'h0;
        instr_reg    <= `JTP_OP_IDCODE;
    end else if (tap_state_reg == `JTP_ST_RESET) begin
        instr_reg    <= `JTP_OP_IDCODE;
    end else if (tck_ris) begin
        case (tap_state_reg)
            `JTP_ST_CAP_IR:   ir_shift_reg <= `JTP_IR_CAPTURE;
            `JTP_ST_SHIFT_IR: ir_shift_reg <= {tdi_s, ir_shift_reg[3:1]};
            `JTP_ST_UPD_IR:   instr_reg    <= ir_shift_reg;
            default:          ir_shift_reg <= ir_shift_reg;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Data registers, one chosen by the latched instruction
localparam SEL_BYP = 3'h0;
localparam SEL_ID  = 3'h1;
localparam SEL_BS  = 3'h2;
localparam SEL_PG  = 3'h3;
localparam SEL_SC  = 3'h4;
localparam SEL_BK  = 3'h5;
reg [2:0] dr_sel;
always @* begin
    case (instr_reg)
        `JTP_OP_IDCODE:   dr_sel = SEL_ID;
        `JTP_OP_EXTEST:   dr_sel = SEL_BS;
        `JTP_OP_SAMPLE:   dr_sel = SEL_BS;
        `JTP_OP_PROG_EN:  dr_sel = SEL_PG;
        `JTP_OP_PROG_CMD: dr_sel = SEL_PG;
        `JTP_OP_PRIV0:    dr_sel = SEL_SC;
        `JTP_OP_PRIV1:    dr_sel = SEL_BK;
        default:          dr_sel = SEL_BYP;
    endcase
end

reg            byp_reg;
reg [31:0]     id_reg;
reg [BS_W-1:0] bs_reg;
reg [PG_W-1:0] pg_reg;
reg [SC_W-1:0] sc_reg;
reg [SC_W-1:0] bk_reg;

// Two-entry buffer toward the programming engine
reg [PG_W-1:0] buf_mem [0:1];
reg            wr_ptr_reg;
reg            rd_ptr_reg;
reg [1:0]      cnt_reg;
wire buf_full  = (cnt_reg == 2'h2);
wire buf_push  = tck_ris & st_upd_dr & (dr_sel == SEL_PG) & ~buf_full;
wire buf_pop   = prog_valid & prog_ready;
assign prog_valid = (cnt_reg != 2'h0);
wire rd_ptr_next = buf_pop ? ~rd_ptr_reg : rd_ptr_reg;

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        byp_reg     <= 1'b0;
        id_reg      <= 32'h0;
        bs_reg      <= {BS_W{1'b0}};
        pg_reg      <= {PG_W{1'b0}};
        sc_reg      <= {SC_W{1'b0}};
        bk_reg      <= {SC_W{1'b0}};
        bs_update   <= {BS_W{1'b0}};
        scan_update <= {SC_W{1'b0}};
        brk_update  <= {SC_W{1'b0}};
    end else if (tck_ris && st_cap_dr) begin
        byp_reg <= 1'b0;
        case (dr_sel)
            SEL_ID:  id_reg <= ID_VALUE;
            SEL_BS:  bs_reg <= bs_capture;
            SEL_PG:  pg_reg <= prog_capture;
            SEL_SC:  sc_reg <= scan_capture;
            SEL_BK:  bk_reg <= brk_update;
            default: byp_reg <= 1'b0;
        endcase
    end else if (tck_ris && st_shift_dr) begin
        case (dr_sel)
            SEL_ID:  id_reg  <= {tdi_s, id_reg[31:1]};
            SEL_BS:  bs_reg  <= {tdi_s, bs_reg[BS_W-1:1]};
            SEL_PG:  pg_reg  <= {tdi_s, pg_reg[PG_W-1:1]};
            SEL_SC:  sc_reg  <= {tdi_s, sc_reg[SC_W-1:1]};
            SEL_BK:  bk_reg  <= {tdi_s, bk_reg[SC_W-1:1]};
            default: byp_reg <= tdi_s;
        endcase
    end else if (tck_ris && st_upd_dr) begin
        case (dr_sel)
            SEL_BS:  bs_update   <= bs_reg;
            SEL_SC:  scan_update <= sc_reg;
            SEL_BK:  brk_update  <= bk_reg;
            default: byp_reg     <= byp_reg;
        endcase
    end
end

// Buffer pointers; a full buffer drops the update, tester must pace
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        wr_ptr_reg <= 1'b0;
        rd_ptr_reg <= 1'b0;
        cnt_reg    <= 2'h0;
        prog_data  <= {PG_W{1'b0}};
    end else begin
        if (buf_push) begin
            buf_mem[wr_ptr_reg] <= pg_reg;
            wr_ptr_reg          <= ~wr_ptr_reg;
        end
        if (buf_pop)
            rd_ptr_reg <= ~rd_ptr_reg;
        cnt_reg   <= cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
        // A word landing in the slot that becomes head skips the array read,
        // so prog_data is already valid in the first cycle of prog_valid
        if (buf_push && (wr_ptr_reg == rd_ptr_next))
            prog_data <= pg_reg;
        else
            prog_data <= buf_mem[rd_ptr_next];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Output stage, changes on falling test clock
reg tdo_mux;
always @* begin
    if (st_shift_ir)
        tdo_mux = ir_shift_reg[0];
    else begin
        case (dr_sel)
            SEL_ID:  tdo_mux = id_reg[0];
            SEL_BS:  tdo_mux = bs_reg[0];
            SEL_PG:  tdo_mux = pg_reg[0];
            SEL_SC:  tdo_mux = sc_reg[0];
            SEL_BK:  tdo_mux = bk_reg[0];
            default: tdo_mux = byp_reg;
        endcase
    end
end

reg tdo_reg;
reg tdo_oe_reg;
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        tdo_reg    <= 1'b0;
        tdo_oe_reg <= 1'b0;
    end else if (!tap_active) begin
        tdo_oe_reg <= 1'b0;
    end else if (tck_fal) begin
        tdo_reg    <= tdo_mux;
        tdo_oe_reg <= st_shift_ir | st_shift_dr;
    end
end
assign tdo_out = tdo_reg;
assign tdo_oe  = tdo_oe_reg;

endmodule
`default_nettype wire

//--- include/jtp_defines.vh
// Constants for the test access port block
//
// Summary of operation
// - Controller steps on rising test clock edges, path chosen by sampled mode select.
// - Either instruction or one data register sits between data in and out.
// - Latched instruction picks the data register and how it behaves.
// - Identification, one-bit bypass and boundary-scan registers exist for board test.
// - Programming interface register selectable for serial memory programming.
// - Internal scan and break-point scan chains exist for debug only.
// - Exactly four pins: mode select, test clock, data in, data out.
// - Data in shifts into selected register; data out comes from it.
// - No test reset pin; the tester resets the controller with mode select.
// - Fuse unprogrammed: pins are plain port pins and controller held reset.
// - Fuse programmed, disable bit clear: inputs pulled high, port enabled.
// - Data out is driven from a falling test clock in a shift state to the next falling clock in Exit1; undriven otherwise.
// - Fuse delivered programmed, so the port is active by default.
// - Sixteen-state controller, in Test-Logic-Reset after power-on.
// - Every shift register moves least significant bit first.
// - Four-bit instructions; capture value 0x01 shifts out during instruction load.
// - Five test clocks with mode select high always reach Test-Logic-Reset.
`ifndef JTP_DEFINES_VH
`define JTP_DEFINES_VH

// Controller states
`define JTP_ST_RESET      4'h0
`define JTP_ST_IDLE       4'h1
`define JTP_ST_SEL_DR     4'h2
`define JTP_ST_CAP_DR     4'h3
`define JTP_ST_SHIFT_DR   4'h4
`define JTP_ST_EXIT1_DR   4'h5
`define JTP_ST_PAUSE_DR   4'h6
`define JTP_ST_EXIT2_DR   4'h7
`define JTP_ST_UPD_DR     4'h8
`define JTP_ST_SEL_IR     4'h9
`define JTP_ST_CAP_IR     4'hA
`define JTP_ST_SHIFT_IR   4'hB
`define JTP_ST_EXIT1_IR   4'hC
`define JTP_ST_PAUSE_IR   4'hD
`define JTP_ST_EXIT2_IR   4'hE
`define JTP_ST_UPD_IR     4'hF

// Instruction register
`define JTP_IR_W          4
`define JTP_IR_CAPTURE    4'h1
// Instruction codes
`define JTP_OP_EXTEST     4'h0
`define JTP_OP_IDCODE     4'h1
`define JTP_OP_SAMPLE     4'h2
`define JTP_OP_PROG_EN    4'h4
`define JTP_OP_PROG_CMD   4'h5
`define JTP_OP_PRIV0      4'h8
`define JTP_OP_PRIV1      4'h9
`define JTP_OP_BYPASS     4'hF

// Data register lengths
`define JTP_ID_W          32
`define JTP_BS_W          8
`define JTP_PG_W          16
`define JTP_SC_W          16

// Fuse delivered programmed
`define JTP_FUSE_DEFAULT  1'b1

`endif

//--- testbench/jtp_tap_port_monitor.sv
// Checker on the test access port top-level ports
`timescale 1ns/1ps
`default_nettype none
`include "jtp_defines.vh"
module jtp_tap_port_monitor #(
    parameter PG_W = 16
) (
    input wire logic            clk,
    input wire logic            resetn,
    input wire logic            tap_enable_fuse,
    input wire logic            tap_disable_bit,
    input wire logic            tck_pin,
    input wire logic            tdo_oe,
    input wire logic            tap_active,
    input wire logic            tap_pullup_en,
    input wire logic [PG_W-1:0] prog_data,
    input wire logic            prog_valid,
    input wire logic            prog_ready,
    input wire logic [3:0]      instr_reg,
    input wire logic [3:0]      tap_state_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////
    // Enable decode and pull-ups
    enable_decode_a: assert property (tap_active == (tap_enable_fuse && !tap_disable_bit))
        else $error("tap_active does not follow fuse and disable bit");
    pullup_follow_a: assert property (tap_pullup_en == tap_active)
        else $error("pull-up enable differs from port enable");
    disabled_reset_a: assert property (!tap_active [*2] |-> tap_state_reg == `JTP_ST_RESET && !tdo_oe)
        else $error("disabled port not held in reset");
    // Data out driven only around the shift states
    tdo_float_a: assert property (tdo_oe |-> tap_state_reg inside {`JTP_ST_SHIFT_DR,
        `JTP_ST_EXIT1_DR, `JTP_ST_SHIFT_IR, `JTP_ST_EXIT1_IR})
        else $error("data out driven outside shifting");
    // Pin sync delay lets state move only just after a rise, enable only after a fall
    state_on_rise_a: assert property (tap_active && $past(tap_active) && $changed(tap_state_reg)
        |-> $past(tck_pin, 2)) else $error("state moved without a test clock rise");
    oe_on_fall_a: assert property (tap_active && $past(tap_active) && $changed(tdo_oe)
        |-> !$past(tck_pin, 2)) else $error("data out enable moved without a fall");
    shift_exit_a: assert property (tap_active && $past(tap_state_reg) == `JTP_ST_SHIFT_IR &&
        tap_state_reg != `JTP_ST_SHIFT_IR |-> tap_state_reg == `JTP_ST_EXIT1_IR)
        else $error("illegal step out of instruction shift");
    idcode_reload_a: assert property ($past(tap_state_reg) == `JTP_ST_RESET &&
        tap_state_reg == `JTP_ST_RESET |-> instr_reg == `JTP_OP_IDCODE)
        else $error("reset state without identification instruction");
    prog_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_data))
        else $error("programming word lost while stalled");
    cover_ir_shift: cover property (tap_state_reg == `JTP_ST_SHIFT_IR && tdo_oe);
    cover_prog_pop: cover property (prog_valid && prog_ready);
    cover_disabled: cover property (!tap_active);
endmodule
bind jtp_tap_port jtp_tap_port_monitor #(.PG_W(PG_W)) u_mon (.clk(clk), .resetn(resetn),
    .tap_enable_fuse(tap_enable_fuse), .tap_disable_bit(tap_disable_bit), .tck_pin(tck_pin),
    .tdo_oe(tdo_oe), .tap_active(tap_active), .tap_pullup_en(tap_pullup_en),
    .prog_data(prog_data), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .instr_reg(instr_reg), .tap_state_reg(tap_state_reg));
`default_nettype wire

//--- testbench/jtp_tester.sv
// Tester model driving three port pins and reading data out
`timescale 1ns/1ps
`default_nettype none
module jtp_tester (
    input  wire logic clk,
    input  wire logic resetn,
    output var  logic rst_pull_n,
    input  wire logic tdo_out,
    input  wire logic tdo_oe,
    output var  logic tck_pin,
    output var  logic tms_pin,
    output var  logic tdi_pin
);
    // Test clock parked low between frames
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tdi_pin = 1'b1;
        rst_pull_n = 1'b1;
    end
    // Watch the shared reset line; counts resets from any source
    logic rst_last = 1'b1;
    int   n_rst_seen = 0;
    always @(posedge clk) begin
        if (!resetn && rst_last)
            n_rst_seen++;
        rst_last <= resetn;
    end
    // Open-collector pull on the shared reset line; released reads high
    task pull_reset(input int n);
        rst_pull_n = 1'b0;
        repeat (n) @(negedge clk);
        rst_pull_n = 1'b1;
    endtask
    // One 320 ns test clock; data out read at the end of the low phase
    task step(input logic tms, input logic tdi, output logic tdo);
        tms_pin = tms;
        tdi_pin = tdi;
        repeat (4) @(negedge clk);
        tdo = tdo_oe ? tdo_out : 1'b1; // Released line reads the pull-up
        tck_pin = 1'b1;
        repeat (4) @(negedge clk);
        tck_pin = 1'b0;
    endtask
    // Navigation only; data in toggles so stale values never look valid
    task walk(input logic [7:0] seq, input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            step(seq[i], ~tdi_pin, b);
        end
    endtask
    // Shift LSB first, leaving on the last bit
    task shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
    endtask
endmodule
`default_nettype wire

//--- testbench/test_jtp_tap_port.sv
// Self-checking bench for the test access port
`timescale 1ns/1ps
`default_nettype none
`include "jtp_defines.vh"
module test_jtp_tap_port;
    localparam [31:0] ID = 32'h0ACE_5001; // Arbitrary identification value
    logic        clk, resetn, fuse, dis, tck, tms, tdi, tdo, oe, act, pu, pv, pr;
    logic [7:0]  bsu;
    logic [15:0] pd, scu, bku;
    logic [3:0]  ir, st;
    logic [31:0] d;
    logic        rst_drv_n, pull_n;
    // Shared reset line: bench driver and debugger pull, both open-collector
    assign resetn = rst_drv_n & pull_n;
    int          n_mismatch = 0, n_checks = 0, cycles = 0;
    jtp_tap_port #(.ID_VALUE(ID)) uut (.clk(clk), .resetn(resetn), .tap_enable_fuse(fuse),
        .tap_disable_bit(dis), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi), .tdo_out(tdo),
        .tdo_oe(oe), .tap_active(act), .tap_pullup_en(pu), .bs_capture(8'h5A),
        .bs_update(bsu), .prog_capture(16'hC3A1), .prog_data(pd), .prog_valid(pv),
        .prog_ready(pr), .scan_capture(16'h9E47), .scan_update(scu), .brk_update(bku),
        .instr_reg(ir), .tap_state_reg(st));
    jtp_tester far (.clk(clk), .resetn(resetn), .rst_pull_n(pull_n), .tdo_out(tdo),
        .tdo_oe(oe), .tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi));
    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // From idle: load an instruction, back to idle
    task load_ir(input logic [3:0] code);
        far.walk(8'h03, 4);
        far.shift(4, code, d);
        chk("ir capture", 32'h1, d);
        far.walk(8'h01, 2);
        chk("instr", code, ir);
    endtask
    // From idle: one data register pass, back to idle
    task dr(input int n, input logic [31:0] din);
        far.walk(8'h01, 3);
        far.shift(n, din, d);
        far.walk(8'h01, 2);
    endtask
    task t_basic;
        chk("state", `JTP_ST_RESET, st);
        chk("instr", `JTP_OP_IDCODE, ir);
        chk("oe", 0, oe);
        far.walk(8'h00, 1);
        dr(32, 0);
        chk("idcode", ID, d);
        load_ir(`JTP_OP_BYPASS);
        dr(8, 8'hA5);
        chk("bypass", 32'h4A, d);
        $display("test basic done");
    endtask
    task t_chains;
        logic [3:0]  op [4];
        logic [31:0] cap;
        op = '{`JTP_OP_EXTEST, `JTP_OP_SAMPLE, `JTP_OP_PRIV0, `JTP_OP_PRIV1};
        for (int i = 0; i < 4; i++) begin
            load_ir(op[i]);
            dr(i < 2 ? 8 : 16, 32'h6C3B + i);
            // Break chain recaptures its own latched update, zero out of reset
            cap = i < 2 ? 32'h5A : (i == 2 ? 32'h9E47 : 32'h0);
            chk("capture", cap, i < 2 ? d[7:0] : d[15:0]);
            if (i == 0) chk("bs update", 32'h3B, bsu);
        end
        chk("scan update", 32'h6C3D, scu);
        chk("brk update", 32'h6C3E, bku);
        dr(16, 32'h0);
        chk("brk readback", 32'h6C3E, d);
        $display("test chains done");
    endtask
    task pop(input logic [15:0] exp);
        chk("prog valid", 1, pv);
        chk("prog data", exp, pd);
        pr = 1'b1;
        @(negedge clk);
        pr = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    // Receiver stalls through three pushes; the third is refused
    task t_prog;
        load_ir(`JTP_OP_PROG_EN);
        load_ir(`JTP_OP_PROG_CMD);
        dr(16, 32'h1111);
        chk("prog capture", 32'hC3A1, d);
        dr(16, 32'h2222);
        dr(16, 32'h3333);
        pop(16'h1111);
        pop(16'h2222);
        chk("prog empty", 0, pv);
        $display("test prog done");
    endtask
    task t_tms_reset;
        far.walk(8'h01, 3);
        far.walk(8'h1F, 5);
        chk("state", `JTP_ST_RESET, st);
        chk("instr", `JTP_OP_IDCODE, ir);
        far.walk(8'h00, 1);
        $display("test tms reset done");
    endtask
    task t_enable;
        dis = 1'b1;
        far.walk(8'h00, 2);
        chk("active", 0, act);
        chk("pullup", 0, pu);
        chk("state", `JTP_ST_RESET, st);
        dis = 1'b0;
        fuse = 1'b0;
        @(negedge clk);
        chk("active", 0, act);
        fuse = `JTP_FUSE_DEFAULT;
        @(negedge clk);
        chk("active", 1, act);
        $display("test enable done");
    endtask
    // Debugger pulls the shared reset low in mid-run, then reuses the port
    task t_dbg_reset;
        far.walk(8'h00, 1);
        load_ir(`JTP_OP_BYPASS);
        far.pull_reset(4);
        chk("state", `JTP_ST_RESET, st);
        chk("instr", `JTP_OP_IDCODE, ir);
        chk("prog flushed", 0, pv);
        chk("resets seen", 2, far.n_rst_seen);
        far.walk(8'h00, 1);
        dr(32, 0);
        chk("idcode", ID, d);
        $display("test debugger reset done");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        fuse = 1'b1;
        dis = 1'b0;
        pr = 1'b0;
        rst_drv_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_drv_n = 1'b1;
        repeat (4) @(negedge clk);
        t_basic();
        t_chains();
        t_prog();
        t_tms_reset();
        t_enable();
        t_dbg_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
